// >>> pkg/sdp_pkg.sv
// Shared constants, types and helper functions of the serial data and prescaler block
package sdp_pkg;

    localparam int NUM_CH = 4;
    localparam int DATA_W = 9;
    localparam int DIV_LSB = 9;
    localparam int DIV_W = 7;
    localparam int PCNT_W = 15;
    localparam int GATE_BIT = 2;

    localparam logic [19:0] ADDR_GATE = 20'hF_00F0;
    localparam logic [19:0] ADDR_PRESC = 20'hF_0126;
    localparam logic [19:0] ADDR_BUF0 = 20'hF_FF10;
    localparam logic [19:0] ADDR_BUF1 = 20'hF_FF12;
    localparam logic [19:0] ADDR_BUF2 = 20'hF_FF44;
    localparam logic [19:0] ADDR_BUF3 = 20'hF_FF46;
    localparam logic [3:0][19:0] BUF_ADDR = {ADDR_BUF3, ADDR_BUF2, ADDR_BUF1, ADDR_BUF0};

    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [15:0] PRESC_RESET = 16'h0000;
    localparam logic [15:0] BUF_RESET = 16'h0000;
    localparam logic [7:0] GATE_WMASK = 8'hB5;
    localparam logic [15:0] PRESC_WMASK = 16'h00FF;
    localparam logic [3:0] CH9_MASK = 4'h3;
    localparam logic [8:0] WORD_ZERO = 9'h000;

    typedef enum logic [1:0] {
        LEN_RSVD = 2'b00,
        LEN_9 = 2'b01,
        LEN_7 = 2'b10,
        LEN_8 = 2'b11
    } sdp_len_t;

    // Right-aligned valid bits of one character
    function automatic logic [8:0] len_mask(input logic [1:0] len, input logic wide9);
        logic [8:0] m;
        case (sdp_len_t'(len))
            LEN_7: m = 9'h07F;
            LEN_9: m = wide9 ? 9'h1FF : 9'h0FF;
            default: m = 9'h0FF;
        endcase
        return m;
    endfunction : len_mask

    // Code k gives one enable in every 2**k system clocks
    function automatic logic presc_hit(input logic [14:0] cnt, input logic [3:0] code);
        logic [15:0] m;
        m = (16'h0001 << code) - 16'h0001;
        return (({1'b0, cnt} & m) == m);
    endfunction : presc_hit

    function automatic logic [1:0] first_one(input logic [3:0] v);
        logic [1:0] idx;
        idx = 2'h0;
        if (!v[0] && v[1]) idx = 2'h1;
        else if (!v[0] && !v[1] && v[2]) idx = 2'h2;
        else if (!v[0] && !v[1] && !v[2]) idx = 2'h3;
        return idx;
    endfunction : first_one

endpackage : sdp_pkg

// >>> rtl/sdp_core.sv
// Serial unit data buffers, shift registers, shared prescaler and unit clock gate
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Each channel has a nine-bit shift register
// - Nine-bit characters use shift bits zero to eight
// - Shift register reachable only through buffer bits
// - Buffer is 16 bits, divider in 15:9
// - Received word stored, written word shifted out
// - Buffer data right-aligned by data length
// - Bits beyond length read zero after reception
// - Word access plus low-byte aliases
// - Low-byte write clears divider bits 15:9
// - Buffers reset to zero
// - Gate bit two off: clock stopped, reset
// - Gate off: registers read defaults, ignore writes
// - Enable register resets zero, bits 1,3,6 zero
// - Prescaler gives two shared operation clocks
// - Code k divides system clock by 2**k
// - Prescaler accepts word and low-byte writes
// - Prescaler resets zero, upper byte zero
// - Transfer clock divides by upper seven buffer bits plus one
// - Select bit picks operation clock a or b
module sdp_core
    import sdp_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_CE,
    input wire logic [19:0] I_ADDR,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_WIDE,
    input wire logic [15:0] I_WDATA,
    output logic [15:0] O_RDATA,
    input wire logic [7:0] I_DATA_LEN,
    input wire logic [3:0] I_MSB_FIRST,
    input wire logic [3:0] I_OPCLK_SEL,
    input wire logic [3:0] I_XCLK_SRC,
    input wire logic [3:0] I_EXT_TICK,
    input wire logic [3:0] I_TX_LOAD,
    input wire logic [3:0] I_RX_DONE,
    input wire logic [3:0] I_SHIFT,
    input wire logic [3:0] I_SER_IN,
    output logic [3:0] O_SER_OUT,
    output logic [3:0] O_XFER_TICK,
    output logic O_OPCLK_A,
    output logic O_OPCLK_B,
    output logic O_UNIT_RUN,
    output logic [7:0] O_PERIPH_EN,
    output logic O_RX_READY
);
    logic [7:0] per_reg;
    logic [7:0] per_next;
    logic [15:0] presc_reg;
    logic [15:0] presc_next;
    logic [14:0] presc_cnt_reg;
    logic opa_reg;
    logic opb_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [15:0] rd_word;
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] pin_reg;
    logic [3:0] pend_reg;
    logic [3:0] pend_next;

    wire [3:0] buf_hit;
    wire [3:0] ser_out;
    wire [3:0] xtick;
    wire [3:0] fmck;
    wire [8:0] sh_word [NUM_CH];
    wire [8:0] ld_word [NUM_CH];
    wire [15:0] buf_q [NUM_CH];

    wire logic gate_on = per_reg[GATE_BIT];
    wire logic wr_ok = I_WR & gate_on;
    wire logic per_hit = I_WR & (I_ADDR == ADDR_GATE);
    wire logic presc_hit_w = wr_ok & (I_ADDR == ADDR_PRESC);
    wire logic [19:0] rd_base = {I_ADDR[19:1], 1'b0};

    // Received words wait here so a busy buffer port costs no character
    wire logic push_valid = |pend_reg;
    wire logic push_ready;
    wire logic [1:0] push_ch = first_one(pend_reg);
    wire logic [10:0] push_data = {push_ch, sh_word[push_ch]};
    wire logic push_fire = push_valid & push_ready;
    wire logic drain_valid;
    wire logic [10:0] drain_data;
    wire logic [1:0] drain_ch = drain_data[10:9];
    wire logic drain_ready = ~buf_hit[drain_ch];
    wire logic drain_fire = drain_valid & drain_ready;

    // Register writes
    assign per_next = per_hit ? (I_WDATA[7:0] & GATE_WMASK) : per_reg;
    assign presc_next = presc_hit_w ? ({8'h00, I_WDATA[7:0]} & PRESC_WMASK) : presc_reg;

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            per_reg <= GATE_RESET;
            presc_reg <= PRESC_RESET;
        end else if (I_CE) begin
            per_reg <= per_next;
            presc_reg <= gate_on ? presc_next : PRESC_RESET;
        end
    end

    // Prescaler counts only while the unit clock runs
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            presc_cnt_reg <= '0;
            opa_reg <= 1'b0;
            opb_reg <= 1'b0;
        end else if (I_CE) begin
            presc_cnt_reg <= gate_on ? presc_cnt_reg + 15'h0001 : '0;
            opa_reg <= gate_on & presc_hit(presc_cnt_reg, presc_reg[3:0]);
            opb_reg <= gate_on & presc_hit(presc_cnt_reg, presc_reg[7:4]);
        end
    end

    // Pin inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s1_reg <= 4'hF;
            s2_reg <= 4'hF;
            s3_reg <= 4'hF;
            pin_reg <= 4'hF;
        end else if (I_CE) begin
            s1_reg <= I_SER_IN;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= ((s2_reg ~^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & pin_reg);
        end
    end

    // A completion in the cycle its pending flag is taken is kept
    assign pend_next = (pend_reg & ~(push_fire ? (4'h1 << push_ch) : 4'h0))
                       | (I_RX_DONE & {4{gate_on}});

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pend_reg <= 4'h0;
        end else if (I_CE) begin
            pend_reg <= gate_on ? pend_next : 4'h0;
        end
    end

    sdp_fifo2 #(.W(11)) u_rx_buf (
        .i_clk(I_MCLK),
        .i_arst_n(I_ARST_N),
        .i_ce(I_CE),
        .i_clr(~gate_on),
        .i_valid(push_valid),
        .o_ready(push_ready),
        .i_data(push_data),
        .o_valid(drain_valid),
        .i_ready(drain_ready),
        .o_data(drain_data)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [15:0] buf_reg;
            logic [15:0] buf_next;
            logic [6:0] div_cnt_reg;
            logic tick_reg;
            wire logic [8:0] mask = len_mask(I_DATA_LEN[2*g +: 2], CH9_MASK[g]);
            wire logic [15:0] wmask = {7'h7F, CH9_MASK[g], 8'hFF};
            wire logic rx_wr = drain_fire & (drain_ch == 2'(g));
            wire logic div_hit = fmck[g] & (div_cnt_reg == buf_reg[15:DIV_LSB]);

            assign buf_hit[g] = wr_ok & (I_ADDR == BUF_ADDR[g]);
            assign ld_word[g] = buf_reg[8:0] & mask;
            assign buf_q[g] = buf_reg;
            assign fmck[g] = I_OPCLK_SEL[g] ? opb_reg : opa_reg;
            assign xtick[g] = tick_reg;

            always_comb begin
                buf_next = buf_reg;
                if (buf_hit[g] && I_WIDE) buf_next = I_WDATA & wmask;
                else if (buf_hit[g]) buf_next = {7'h00, buf_reg[8], I_WDATA[7:0]};
                else if (rx_wr) buf_next = {buf_reg[15:DIV_LSB], drain_data[8:0] & mask};
            end

            always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    buf_reg <= BUF_RESET;
                    div_cnt_reg <= '0;
                    tick_reg <= 1'b0;
                end else if (I_CE) begin
                    buf_reg <= gate_on ? buf_next : BUF_RESET;
                    div_cnt_reg <= (!gate_on || div_hit) ? '0 : div_cnt_reg + {6'h00, fmck[g]};
                    tick_reg <= gate_on & (I_XCLK_SRC[g] ? I_EXT_TICK[g] : div_hit);
                end
            end

            sdp_shift u_shift (
                .i_clk(I_MCLK),
                .i_arst_n(I_ARST_N),
                .i_ce(I_CE),
                .i_clr(~gate_on),
                .i_load(I_TX_LOAD[g]),
                .i_load_word(ld_word[g]),
                .i_shift(I_SHIFT[g]),
                .i_ser(pin_reg[g]),
                .i_msb_first(I_MSB_FIRST[g]),
                .i_mask(mask),
                .o_ser(ser_out[g]),
                .o_word(sh_word[g])
            );
        end
    endgenerate

    // Read side: only the buffers expose channel data, never the shift registers
    always_comb begin
        rd_word = 16'h0000;
        if (I_ADDR == ADDR_GATE) rd_word = {8'h00, per_reg};
        else if (rd_base == ADDR_PRESC) rd_word = presc_reg;
        else if (rd_base == ADDR_BUF0) rd_word = buf_q[0];
        else if (rd_base == ADDR_BUF1) rd_word = buf_q[1];
        else if (rd_base == ADDR_BUF2) rd_word = buf_q[2];
        else if (rd_base == ADDR_BUF3) rd_word = buf_q[3];
    end

    assign rdata_next = !I_RD ? rdata_reg
                      : I_WIDE ? rd_word
                      : I_ADDR[0] ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_reg <= 16'h0000;
        end else if (I_CE) begin
            rdata_reg <= rdata_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_SER_OUT = ser_out;
    assign O_XFER_TICK = xtick;
    assign O_OPCLK_A = opa_reg;
    assign O_OPCLK_B = opb_reg;
    assign O_UNIT_RUN = gate_on;
    assign O_PERIPH_EN = per_reg;
    assign O_RX_READY = push_ready;

    // Checks
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_ARST_N);

    wire logic b_cnt_low_ones = (presc_cnt_reg[1:0] == 2'h3);
    wire logic [8:0] ch0_mask = len_mask(I_DATA_LEN[1:0], CH9_MASK[0]);
    wire logic div_cnt_reg_zero0 = (g_ch[0].div_cnt_reg == 7'h00);

    sequence s_byte_wr0;
        I_CE && wr_ok && !I_WIDE && (I_ADDR == ADDR_BUF0);
    endsequence

    sequence s_rx_store0;
        I_CE && gate_on && drain_fire && (drain_ch == 2'h0) && !buf_hit[0];
    endsequence

    sequence s_tx_load0;
        I_CE && gate_on && I_TX_LOAD[0];
    endsequence

    a_buf_gate_clear: assert property (
        (I_CE && !gate_on) |=> (buf_q[0] == BUF_RESET) && (buf_q[3] == BUF_RESET)
            && (presc_reg == PRESC_RESET))
        else $error("unit state not cleared while gate is off");

    a_byte_clears_div: assert property (
        s_byte_wr0 |=> (buf_q[0][15:9] == 7'h00) && (buf_q[0][7:0] == $past(I_WDATA[7:0])))
        else $error("byte write did not clear divider bits");

    a_rx_zero_fill: assert property (
        (s_rx_store0 and (I_DATA_LEN[1:0] == $past(I_DATA_LEN[1:0])))
            |=> ((buf_q[0][8:0] & ~ch0_mask) == 9'h000))
        else $error("bits beyond data length not zero after reception");

    a_tx_load_word: assert property (
        s_tx_load0 |=> (sh_word[0] == $past(ld_word[0])))
        else $error("shift register not loaded from buffer");

    a_presc_code0: assert property (
        (I_CE && gate_on && presc_reg[3:0] == 4'h0) |=> O_OPCLK_A)
        else $error("code zero did not give undivided clock");

    a_presc_div4: assert property (
        (I_CE && gate_on && presc_reg[7:4] == 4'h2) |=> (O_OPCLK_B == $past(b_cnt_low_ones)))
        else $error("operation clock b not one in four");

    a_presc_upper: assert property (
        presc_reg[15:8] == 8'h00)
        else $error("prescaler upper byte not zero");

    a_gate_rsvd: assert property (
        (per_reg & ~GATE_WMASK) == 8'h00)
        else $error("reserved enable bits not zero");

    a_read_default: assert property (
        (I_CE && I_RD && I_WIDE && !gate_on && (I_ADDR == ADDR_BUF1)) |=> (O_RDATA == 16'h0000))
        else $error("buffer read not default while gate off");

    a_xfer_div0: assert property (
        (I_CE && gate_on && !I_XCLK_SRC[0] && fmck[0] && buf_q[0][15:9] == 7'h00
            && div_cnt_reg_zero0) |=> O_XFER_TICK[0])
        else $error("divide ratio zero gave no transfer tick");

    a_buf_hold: assert property (
        (I_CE && gate_on && !buf_hit[2] && !(drain_fire && drain_ch == 2'h2))
            |=> $stable(buf_q[2]))
        else $error("buffer changed without write or reception");

    a_ext_tick_src: assert property (
        (I_CE && gate_on && I_XCLK_SRC[0]) |=> (O_XFER_TICK[0] == $past(I_EXT_TICK[0])))
        else $error("external tick not passed to transfer clock");

    a_ser_idle_off: assert property (
        (I_CE && !gate_on) |=> (O_SER_OUT == 4'hF))
        else $error("serial output not idle while unit is held in reset");

    a_presc_byte_wr: assert property (
        (I_CE && wr_ok && !I_WIDE && I_ADDR == ADDR_PRESC)
            |=> (presc_reg == {8'h00, $past(I_WDATA[7:0])}))
        else $error("prescaler low byte write not taken");

    a_rx_keeps_div: assert property (
        s_rx_store0 |=> (buf_q[0][15:9] == $past(buf_q[0][15:9])))
        else $error("reception changed divider bits");

    a_word_wr_ch2: assert property (
        (I_CE && wr_ok && I_WIDE && I_ADDR == ADDR_BUF2)
            |=> (buf_q[2][8] == 1'b0) && (buf_q[2][15:9] == $past(I_WDATA[15:9])))
        else $error("word write to channel two buffer not taken");
endmodule : sdp_core
`default_nettype wire

// >>> rtl/sdp_fifo2.sv
// Two-entry buffer carrying received words toward the data buffers
`timescale 1ns/100ps
`default_nettype none
module sdp_fifo2 #(
    parameter int W = 11
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [W-1:0] o_data
);
    logic [W-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] cnt_reg;
    wire logic push = i_valid & o_ready;
    wire logic pop = o_valid & i_ready;

    assign o_ready = (cnt_reg != 2'h2);
    assign o_valid = (cnt_reg != 2'h0);
    assign o_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else if (i_ce) begin
            if (i_clr) begin
                wr_ptr_reg <= 1'b0;
                rd_ptr_reg <= 1'b0;
                cnt_reg <= 2'h0;
            end else begin
                wr_ptr_reg <= wr_ptr_reg ^ push;
                rd_ptr_reg <= rd_ptr_reg ^ pop;
                cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end
endmodule : sdp_fifo2
`default_nettype wire

// >>> rtl/sdp_shift.sv
// Nine-bit shift register of one channel
`timescale 1ns/100ps
`default_nettype none
module sdp_shift
    import sdp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_load,
    input wire logic [8:0] i_load_word,
    input wire logic i_shift,
    input wire logic i_ser,
    input wire logic i_msb_first,
    input wire logic [8:0] i_mask,
    output logic o_ser,
    output logic [8:0] o_word
);
    logic [8:0] sh_reg;
    logic [8:0] sh_next;
    logic ser_reg;
    wire logic [8:0] top_bit = i_mask & ~{1'b0, i_mask[8:1]};
    wire logic [8:0] lsb_shift = ({1'b0, sh_reg[8:1]} & i_mask) | (i_ser ? top_bit : WORD_ZERO);
    wire logic [8:0] msb_shift = {sh_reg[7:0], i_ser} & i_mask;

    // Characters stay right-aligned whatever the bit order on the line
    always_comb begin
        sh_next = sh_reg;
        if (i_load) sh_next = i_load_word & i_mask;
        else if (i_shift) sh_next = i_msb_first ? msb_shift : lsb_shift;
    end

    wire logic ser_next = i_msb_first ? |(sh_next & top_bit) : sh_next[0];

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sh_reg <= WORD_ZERO;
            ser_reg <= 1'b1;
        end else if (i_ce) begin
            sh_reg <= i_clr ? WORD_ZERO : sh_next;
            ser_reg <= i_clr ? 1'b1 : ser_next;
        end
    end

    assign o_ser = ser_reg;
    assign o_word = sh_reg;
endmodule : sdp_shift
`default_nettype wire

// >>> verif/test_serial_unit_data_and_prescaler.sv
// Self-checking bench for the serial data buffers, shift registers and prescaler
`timescale 1ns/100ps
`default_nettype none
module test_serial_unit_data_and_prescaler;
    import sdp_pkg::*;

    logic clk, arst_n, ce, wr, rd, wide, oa, ob, run, rxr;
    logic [19:0] addr;
    logic [15:0] wdata, rdata;
    logic [7:0] dlen, pen;
    logic [3:0] osel, txl, rxd, shf, sin, sout, xt, msb, xsrc, ext;
    int miscompares, tests_run;
    logic [15:0] bufm [4];

    // Every control input is driven, so each mode and the clock enable get exercised
    sdp_core u_dut (
        .I_MCLK(clk), .I_ARST_N(arst_n), .I_CE(ce), .I_ADDR(addr), .I_WR(wr), .I_RD(rd),
        .I_WIDE(wide), .I_WDATA(wdata), .O_RDATA(rdata), .I_DATA_LEN(dlen),
        .I_MSB_FIRST(msb), .I_OPCLK_SEL(osel), .I_XCLK_SRC(xsrc), .I_EXT_TICK(ext),
        .I_TX_LOAD(txl), .I_RX_DONE(rxd), .I_SHIFT(shf), .I_SER_IN(sin), .O_SER_OUT(sout),
        .O_XFER_TICK(xt), .O_OPCLK_A(oa), .O_OPCLK_B(ob), .O_UNIT_RUN(run),
        .O_PERIPH_EN(pen), .O_RX_READY(rxr)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
        tests_run++;
        if (act !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, act);
        end
    endtask : chk

    task automatic wreg(input logic [19:0] a, input logic w, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wide = w;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg

    // Read data is sampled one full cycle after the strobe, where it has settled
    task automatic cr(input string what, input logic [19:0] a, input logic w,
                      input logic [15:0] exp);
        @(negedge clk);
        addr = a;
        wide = w;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(what, exp, rdata);
    endtask : cr

    function automatic logic pick(input int s);
        return (s == 0) ? oa : ((s == 1) ? ob : xt[0]);
    endfunction : pick

    // First pass finds a pulse, second skips a possibly short period, third is measured
    task automatic per(input int s, input int exp, input string what);
        int n;
        n = 0;
        for (int p = 0; p < 3; p++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (pick(s) !== 1'b1 && n < 40000);
        end
        chk(what, 16'(exp), 16'(n));
    endtask : per

    task automatic pulse(input int c, input int kind);
        @(negedge clk);
        if (kind == 0) txl[c] = 1'b1;
        else if (kind == 1) shf[c] = 1'b1;
        else rxd[c] = 1'b1;
        @(negedge clk);
        txl = 4'h0;
        shf = 4'h0;
        rxd = 4'h0;
    endtask : pulse

    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        complete_run();
    end

    initial begin
        logic [15:0] v;
        logic [8:0] m, w;
        logic s;
        int r, len, c, code;
        arst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        wide = 1'b1;
        addr = 20'h0_0000;
        wdata = 16'h0000;
        dlen = 8'h00;
        ce = 1'b1;
        msb = 4'h0;
        xsrc = 4'h0;
        ext = 4'h0;
        osel = 4'h0;
        txl = 4'h0;
        rxd = 4'h0;
        shf = 4'h0;
        sin = 4'h0;
        v = 16'($urandom(32'h7946));
        repeat (20) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;

        chk("gate out", 16'h0000, {8'h00, pen});
        chk("run", 16'h0000, {15'h0, run});
        chk("rx ready", 16'h0001, {15'h0, rxr});
        chk("ser out", 16'h000F, {12'h0, sout});
        cr("gate", ADDR_GATE, 1'b0, 16'h0000);
        cr("presc", ADDR_PRESC, 1'b1, 16'h0000);
        for (int i = 0; i < 4; i++) cr("buf", BUF_ADDR[i], 1'b1, 16'h0000);
        $display("reset test done");

        // Unit registers must ignore software while the clock gate is off
        wreg(BUF_ADDR[0], 1'b1, 16'h1234);
        cr("buf off", BUF_ADDR[0], 1'b1, 16'h0000);
        wreg(ADDR_PRESC, 1'b1, 16'h0033);
        cr("presc off", ADDR_PRESC, 1'b1, 16'h0000);
        wreg(ADDR_GATE, 1'b0, 16'h00B5);
        chk("gate out", 16'h00B5, {8'h00, pen});
        chk("run", 16'h0001, {15'h0, run});
        $display("gate test done");

        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            if (i > 1) v[8] = 1'b0;
            wreg(BUF_ADDR[i], 1'b1, v);
            bufm[i] = v & ((i > 1) ? 16'hFEFF : 16'hFFFF);
            cr("buf word", BUF_ADDR[i], 1'b1, bufm[i]);
            v = 16'($urandom);
            wreg(BUF_ADDR[i], 1'b0, {8'h00, v[7:0]});
            bufm[i] = {7'h00, bufm[i][8], v[7:0]};
            cr("buf byte", BUF_ADDR[i], 1'b1, bufm[i]);
            cr("buf low", BUF_ADDR[i], 1'b0, {8'h00, bufm[i][7:0]});
            cr("buf high", BUF_ADDR[i] + 20'h0_0001, 1'b0, {8'h00, bufm[i][15:8]});
        end
        cr("unmapped", 20'hF_0000, 1'b1, 16'h0000);
        $display("buffer test done");

        wreg(ADDR_PRESC, 1'b1, 16'h00FF);
        cr("presc", ADDR_PRESC, 1'b1, 16'h00FF);
        wreg(ADDR_PRESC, 1'b0, 16'h00A5);
        cr("presc byte", ADDR_PRESC, 1'b1, 16'h00A5);
        for (int k = 0; k < 10; k++) begin
            wreg(ADDR_PRESC, 1'b1, {8'h00, 4'(9 - k), 4'(k)});
            per(0, 1 << k, "clock a");
            per(1, 1 << (9 - k), "clock b");
        end
        $display("prescaler test done");

        wreg(ADDR_PRESC, 1'b1, 16'h0010);
        r = int'($urandom % 6) + 1;
        wreg(BUF_ADDR[0], 1'b1, {7'(r), 9'h000});
        per(2, r + 1, "tick a");
        osel = 4'h1;
        per(2, 2 * (r + 1), "tick b");
        xsrc = 4'h1;
        ext = 4'h1;
        @(negedge clk);
        ext = 4'h0;
        chk("ext tick", 16'h0001, {15'h0, xt[0]});
        @(negedge clk);
        chk("ext idle", 16'h0000, {15'h0, xt[0]});
        xsrc = 4'h0;
        osel = 4'h0;
        $display("transfer clock test done");

        for (int i = 0; i < 8; i++) begin
            c = (i < 4) ? 0 : 2;
            code = i % 4;
            dlen[2*c +: 2] = 2'(code);
            m = (code == 2) ? 9'h07F : ((code == 1 && c < 2) ? 9'h1FF : 9'h0FF);
            len = (code == 2) ? 7 : ((code == 1 && c < 2) ? 9 : 8);
            v = 16'($urandom);
            if (c > 1) v[8] = 1'b0;
            wreg(BUF_ADDR[c], 1'b1, v);
            w = v[8:0] & m;
            msb = {3'h0, c == 0 && i % 2 == 1};
            pulse(c, 0);
            @(negedge clk);
            chk("first bit", {15'h0, msb[0] ? w[len - 1] : w[0]}, {15'h0, sout[c]});
            if (c == 0) begin
                s = 1'($urandom);
                sin[0] = s;
                // Input passes a synchroniser, so it must settle before the shift
                repeat (6) @(negedge clk);
                pulse(0, 1);
                @(negedge clk);
                chk("second bit", {15'h0, msb[0] ? w[len - 2] : w[1]}, {15'h0, sout[0]});
                w = msb[0] ? ((w << 1) | 9'(s)) : ((w >> 1) | (9'(s) << (len - 1)));
            end
            pulse(c, 2);
            repeat (10) @(negedge clk);
            cr("rx word", BUF_ADDR[c], 1'b1, {v[15:9], w & m});
            cr("rx held", BUF_ADDR[c], 1'b1, {v[15:9], w & m});
        end

        // All four receptions complete in one cycle and must each land
        dlen = 8'hFF;
        for (int i = 0; i < 4; i++) begin
            bufm[i] = 16'($urandom);
            if (i > 1) bufm[i][8] = 1'b0;
            wreg(BUF_ADDR[i], 1'b1, bufm[i]);
        end
        @(negedge clk);
        txl = 4'hF;
        @(negedge clk);
        txl = 4'h0;
        rxd = 4'hF;
        @(negedge clk);
        rxd = 4'h0;
        repeat (12) @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            cr("rx all", BUF_ADDR[i], 1'b1, {bufm[i][15:9], 1'b0, bufm[i][7:0]});
        end
        // A low clock enable must freeze every register, writes included
        ce = 1'b0;
        wreg(BUF_ADDR[1], 1'b1, ~bufm[1]);
        ce = 1'b1;
        cr("buf frozen", BUF_ADDR[1], 1'b1, {bufm[1][15:9], 1'b0, bufm[1][7:0]});
        $display("receive test done");

        wreg(ADDR_GATE, 1'b0, 16'h0000);
        chk("run", 16'h0000, {15'h0, run});
        cr("buf gated", BUF_ADDR[1], 1'b1, 16'h0000);
        wreg(ADDR_GATE, 1'b0, 16'h0004);
        cr("buf after", BUF_ADDR[1], 1'b1, 16'h0000);
        cr("presc after", ADDR_PRESC, 1'b1, 16'h0000);
        $display("gate clear test done");
        complete_run();
    end
endmodule : test_serial_unit_data_and_prescaler
`default_nettype wire
